/* File: shared/mmap_defines.svh */
// Purpose: address map constants for the processor memory map block
// Assumes: one byte data paths, 16-bit program and external data addresses
// Notes: every offset, field position and reset value lives here
`ifndef MMAP_DEFINES_SVH
`define MMAP_DEFINES_SVH
`define MM_PC_RESET 16'h0000
`define MM_VEC_BASE 16'h0003
`define MM_VEC_SHIFT 3
`define MM_SH_LO 16'h0000
`define MM_SH_HI 16'h13FF
`define MM_CF_LO 16'h2000
`define MM_CF_HI 16'h27FF
`define MM_BB_LO 16'h2800
`define MM_BB_HI 16'h287F
`define MM_CE_HI 16'h03FF
`define MM_CE_MAX_OFF 12'hC00
`define MM_SFR_DPL0 8'h82
`define MM_SFR_DPH0 8'h83
`define MM_SFR_DPL1 8'h84
`define MM_SFR_DPH1 8'h85
`define MM_SFR_DPS 8'h92
`define MM_SFR_PAGE 8'hBF
`define MM_SFR_PSW 8'hD0
`define MM_RST_BYTE 8'h00
`define MM_PSW_RS_HI 4
`define MM_PSW_RS_LO 3
`define MM_BIT_BASE_HI 4'h2
`endif

/* File: shared/mmap_pkg.sv */
// Purpose: types shared by the memory map block
// Assumes: nothing beyond the defines header
// Notes: region codes are one-hot
package mmap_pkg;
  typedef enum logic [3:0] {
    MM_XR_NONE = 4'h1,
    MM_XR_SHARED = 4'h2,
    MM_XR_CFG = 4'h4,
    MM_XR_BAT = 4'h8
  } mmap_region_t;
  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] prog_addr;
    logic [15:0] dp0;
    logic [15:0] dp1;
    logic [7:0] data_pointer_select;
    logic [7:0] page;
    logic [7:0] program_status_word;
    logic id_sfr;
    logic [7:0] sfr_rd;
    logic id_rvalid;
    logic [15:0] ram_addr;
    logic [7:0] ram_wdata;
    logic ram_we;
    mmap_region_t ram_sel;
    logic adc_wr;
    logic rd_pend;
    logic rd_none;
    logic [7:0] xm_rdata;
    logic xm_rvalid;
    logic ce_clash;
    logic [15:0] ce_addr;
    logic ce_err;
  } mmap_top_st_t;
  typedef struct packed {
    logic [255:0][7:0] mem;
    logic [7:0] rdata;
  } mmap_iram_st_t;
endpackage

/* File: shared/mmap_iram_if.sv */
// Purpose: link between the address logic and the internal data RAM
// Assumes: single clock
// Notes: ri_data is a combinational read of the selected pointer byte
`timescale 1ns/1ns
interface mmap_iram_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic bit_en;
  logic [2:0] bit_pos;
  logic [7:0] rdata;
  logic [7:0] ri_addr;
  logic [7:0] ri_data;
  modport host (output req, we, addr, wdata, bit_en, bit_pos, ri_addr, input rdata, ri_data);
  modport mem (input req, we, addr, wdata, bit_en, bit_pos, ri_addr, output rdata, ri_data);
endinterface

/* File: design/mmap_iram.sv */
// Purpose: 256-byte internal data RAM with bit read-modify-write
// Assumes: address already resolved to a RAM byte
// Notes: read data valid the cycle after the request
`timescale 1ns/1ns
`include "mmap_defines.svh"
module mmap_iram import mmap_pkg::*; #(
  parameter int DEPTH = 256
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  mmap_iram_if.mem bus
);
  initial begin
    if (DEPTH != 256) $error("internal RAM depth must be 256");
  end
  mmap_iram_st_t st;
  mmap_iram_st_t next_st;
  logic [7:0] cur;
  assign bus.ri_data = st.mem[bus.ri_addr];
  assign bus.rdata = st.rdata;
  always_comb begin
    next_st = st;
    cur = st.mem[bus.addr];
    if (bus.req) begin
      if (bus.bit_en) begin
        next_st.rdata = {7'h00, cur[bus.bit_pos]};
        if (bus.we) begin
          next_st.mem[bus.addr][bus.bit_pos] = bus.wdata[0];
        end
      end else begin
        next_st.rdata = cur;
        if (bus.we) begin
          next_st.mem[bus.addr] = bus.wdata;
        end
      end
    end
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  a_byte_write_read: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    bus.req && bus.we && !bus.bit_en |=> st.mem[$past(bus.addr)] == $past(bus.wdata))
    else $error("internal RAM byte write lost");
  a_bit_write_one: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    bus.req && bus.we && bus.bit_en |=>
    st.mem[$past(bus.addr)][$past(bus.bit_pos)] == $past(bus.wdata[0]))
    else $error("bit write did not land");
endmodule

/* File: design/mmap_top.sv */
// Purpose: program, external data and internal data address logic
// Assumes: requests are single cycle and synchronous to clk_sys_i
// Notes: unmapped special register reads return zero
// Functional notes
// - program space is 64 KB, fetch and table
// - fetch starts at address zero after reset
// - interrupt entries every eight bytes from 0x0003
// - three external RAM regions are decoded
// - engine owns lowest kilobyte; external data writes flagged, converter writes not
// - converter writes low 0x40 while slots nonzero
// - paged address is page byte plus R0/R1
// - pointer transfers use selected 16-bit pointer
// - select bit picks pointer, contents kept
// - pointer instructions act on selected pointer
// - internal data is 256 bytes, byte address
// - direct upper half is special, indirect RAM
// - lower 32 bytes are four register banks
// - bytes 0x20-0x2F bit addressable; low half both
// - unimplemented special reads return zero, writes ignored
// - special registers at multiples of eight bitwise
// - engine code 1 KB aligned, 3 KB max
// - status bits 4:3 choose bank base
`timescale 1ns/1ns
`include "mmap_defines.svh"
module mmap_top import mmap_pkg::*; #(
  parameter int IRQ_BITS = 5
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic fetch_next_i,
  input wire logic jump_i,
  input wire logic [15:0] jump_addr_i,
  input wire logic irq_take_i,
  input wire logic [IRQ_BITS-1:0] irq_num_i,
  input wire logic movc_i,
  input wire logic movc_use_pc_i,
  input wire logic [7:0] acc_i,
  output logic [15:0] prog_addr_o,
  input wire logic primary_data_pointer_inc_i,
  input wire logic primary_data_pointer_load_i,
  input wire logic [15:0] primary_data_pointer_wdata_i,
  input wire logic id_req_i,
  input wire logic id_we_i,
  input wire logic id_ind_i,
  input wire logic id_rn_i,
  input wire logic id_bit_i,
  input wire logic [7:0] id_addr_i,
  input wire logic [7:0] id_wdata_i,
  output logic [7:0] id_rdata_o,
  output logic id_rvalid_o,
  input wire logic xm_req_i,
  input wire logic xm_we_i,
  input wire logic xm_primary_data_pointer_i,
  input wire logic xm_ri_i,
  input wire logic [7:0] xm_wdata_i,
  output logic xm_ready_o,
  output logic [7:0] xm_rdata_o,
  output logic xm_rvalid_o,
  input wire logic [3:0] mux_slots_i,
  input wire logic adc_req_i,
  input wire logic [5:0] adc_addr_i,
  input wire logic [7:0] adc_wdata_i,
  output logic [15:0] ram_addr_o,
  output logic [7:0] ram_wdata_o,
  output logic ram_we_o,
  output logic [3:0] ram_sel_o,
  input wire logic [7:0] ram_rdata_i,
  output logic ce_clash_o,
  input wire logic [5:0] ce_base_kb_i,
  input wire logic [11:0] ce_off_i,
  output logic [15:0] ce_prog_addr_o,
  output logic ce_range_err_o
);
  initial begin
    if (IRQ_BITS < 1 || IRQ_BITS > 5) $error("IRQ_BITS must be 1 to 5");
  end
  mmap_iram_if ib ();
  mmap_iram u_iram (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .bus(ib.host)
  );
  mmap_top_st_t st;
  mmap_top_st_t next_st;

  function automatic mmap_region_t region(input logic [15:0] a);
    if (a <= `MM_SH_HI) begin
      region = MM_XR_SHARED;
    end else if (a >= `MM_CF_LO && a <= `MM_CF_HI) begin
      region = MM_XR_CFG;
    end else if (a >= `MM_BB_LO && a <= `MM_BB_HI) begin
      region = MM_XR_BAT;
    end else begin
      region = MM_XR_NONE;
    end
  endfunction

  function automatic logic [7:0] sfr_read(input logic [7:0] a, input mmap_top_st_t s);
    case (a)
      `MM_SFR_DPL0: sfr_read = s.dp0[7:0];
      `MM_SFR_DPH0: sfr_read = s.dp0[15:8];
      `MM_SFR_DPL1: sfr_read = s.dp1[7:0];
      `MM_SFR_DPH1: sfr_read = s.dp1[15:8];
      `MM_SFR_DPS: sfr_read = s.data_pointer_select;
      `MM_SFR_PAGE: sfr_read = s.page;
      `MM_SFR_PSW: sfr_read = s.program_status_word;
      default: sfr_read = `MM_RST_BYTE;
    endcase
  endfunction

  logic [1:0] bank;
  logic [15:0] cur_dp;
  logic [15:0] vec;
  logic [15:0] xa;
  logic sfr_hit;
  logic [7:0] sa;
  logic [7:0] sbyte;
  logic [7:0] wbyte;
  logic adc_go;
  mmap_region_t xr;

  assign bank = st.program_status_word[`MM_PSW_RS_HI:`MM_PSW_RS_LO];
  assign cur_dp = st.data_pointer_select[0] ? st.dp1 : st.dp0;
  assign vec = `MM_VEC_BASE + (16'(irq_num_i) << `MM_VEC_SHIFT);
  // only direct upper half is special
  assign sfr_hit = !id_ind_i && !id_rn_i && (id_bit_i ? id_addr_i[7] : id_addr_i[7]);
  // bit address lands on a multiple of eight
  assign sa = id_bit_i ? {id_addr_i[7:3], 3'h0} : id_addr_i;
  assign sbyte = sfr_read(sa, st);
  // converter writes only with nonzero slots
  assign adc_go = adc_req_i && (mux_slots_i != 4'h0);
  assign xm_ready_o = !adc_go;
  // paged address from page byte and pointer register
  assign xa = xm_primary_data_pointer_i ? cur_dp : {st.page, ib.ri_data};
  assign xr = region(xa);

  // register number maps into active bank
  assign ib.ri_addr = {3'h0, bank, 2'h0, xm_ri_i};
  assign ib.req = id_req_i && !sfr_hit;
  assign ib.we = id_we_i;
  assign ib.wdata = id_wdata_i;
  assign ib.bit_en = id_bit_i && !id_rn_i;
  assign ib.bit_pos = id_addr_i[2:0];
  always_comb begin
    if (id_rn_i) begin
      ib.addr = {3'h0, bank, id_addr_i[2:0]};
    end else if (id_bit_i) begin
      // low bit addresses map to 0x20-0x2F
      ib.addr = {`MM_BIT_BASE_HI, id_addr_i[6:3]};
    end else begin
      ib.addr = id_addr_i;
    end
  end

  always_comb begin
    next_st = st;
    next_st.id_rvalid = id_req_i && !id_we_i;
    next_st.xm_rvalid = 1'b0;
    next_st.ram_we = 1'b0;
    next_st.ram_sel = MM_XR_NONE;
    next_st.adc_wr = 1'b0;
    next_st.rd_pend = 1'b0;
    next_st.ce_clash = 1'b0;
    wbyte = id_bit_i ? sbyte : id_wdata_i;
    if (id_bit_i) begin
      wbyte[id_addr_i[2:0]] = id_wdata_i[0];
    end
    if (irq_take_i) begin
      next_st.pc = vec;
    end else if (jump_i) begin
      next_st.pc = jump_addr_i;
    end else if (fetch_next_i) begin
      next_st.pc = st.pc + 16'h0001;
    end
    if (movc_i) begin
      next_st.prog_addr = (movc_use_pc_i ? st.pc : cur_dp) + {8'h00, acc_i};
    end else begin
      next_st.prog_addr = next_st.pc;
    end
    if (id_req_i) begin
      next_st.id_sfr = sfr_hit;
      next_st.sfr_rd = id_bit_i ? {7'h00, sbyte[id_addr_i[2:0]]} : sbyte;
    end
    if (id_req_i && id_we_i && sfr_hit) begin
      case (sa)
        `MM_SFR_DPL0: next_st.dp0[7:0] = wbyte;
        `MM_SFR_DPH0: next_st.dp0[15:8] = wbyte;
        `MM_SFR_DPL1: next_st.dp1[7:0] = wbyte;
        `MM_SFR_DPH1: next_st.dp1[15:8] = wbyte;
        `MM_SFR_DPS: next_st.data_pointer_select = wbyte;
        `MM_SFR_PAGE: next_st.page = wbyte;
        `MM_SFR_PSW: next_st.program_status_word = wbyte;
        default: next_st.program_status_word = st.program_status_word;
      endcase
    end
    if (primary_data_pointer_load_i || primary_data_pointer_inc_i) begin
      if (st.data_pointer_select[0]) begin
        next_st.dp1 = primary_data_pointer_load_i ? primary_data_pointer_wdata_i : st.dp1 + 16'h0001;
      end else begin
        next_st.dp0 = primary_data_pointer_load_i ? primary_data_pointer_wdata_i : st.dp0 + 16'h0001;
      end
    end
    if (adc_go) begin
      next_st.ram_addr = {10'h000, adc_addr_i};
      next_st.ram_wdata = adc_wdata_i;
      next_st.ram_we = 1'b1;
      next_st.ram_sel = MM_XR_SHARED;
      next_st.adc_wr = 1'b1;
    end else if (xm_req_i) begin
      next_st.ram_addr = xa;
      next_st.ram_wdata = xm_wdata_i;
      next_st.ram_sel = xr;
      next_st.ram_we = xm_we_i && (xr != MM_XR_NONE);
      next_st.rd_pend = !xm_we_i;
      next_st.rd_none = (xr == MM_XR_NONE);
      next_st.ce_clash = xm_we_i && (xa <= `MM_CE_HI);
    end
    if (st.rd_pend) begin
      next_st.xm_rvalid = 1'b1;
      next_st.xm_rdata = st.rd_none ? `MM_RST_BYTE : ram_rdata_i;
    end
    next_st.ce_addr = {ce_base_kb_i, 10'h000} + {4'h0, ce_off_i};
    next_st.ce_err = (ce_off_i >= `MM_CE_MAX_OFF);
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
      st.pc <= `MM_PC_RESET;
      st.prog_addr <= `MM_PC_RESET;
      st.ram_sel <= MM_XR_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign prog_addr_o = st.prog_addr;
  assign id_rdata_o = st.id_sfr ? st.sfr_rd : ib.rdata;
  assign id_rvalid_o = st.id_rvalid;
  assign xm_rdata_o = st.xm_rdata;
  assign xm_rvalid_o = st.xm_rvalid;
  assign ram_addr_o = st.ram_addr;
  assign ram_wdata_o = st.ram_wdata;
  assign ram_we_o = st.ram_we;
  assign ram_sel_o = st.ram_sel;
  assign ce_clash_o = st.ce_clash;
  assign ce_prog_addr_o = st.ce_addr;
  assign ce_range_err_o = st.ce_err;

  logic seen;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seen <= 1'b0;
    end else begin
      seen <= 1'b1;
    end
  end

  a_reset_fetch_zero: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !seen |-> prog_addr_o == 16'h0000)
    else $error("first fetch not at zero");
  a_vector_spacing: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    irq_take_i && !movc_i |=> prog_addr_o == 16'h0003 + 16'($past(irq_num_i)) * 16'h0008)
    else $error("vector address wrong");
  a_paged_addr: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    xm_req_i && xm_ready_o && !xm_primary_data_pointer_i |=> ram_addr_o[15:8] == $past(st.page))
    else $error("paged high byte wrong");
  a_primary_data_pointer_addr: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    xm_req_i && xm_ready_o && xm_primary_data_pointer_i
    |=> ram_addr_o == ($past(st.data_pointer_select[0]) ? $past(st.dp1) : $past(st.dp0)))
    else $error("pointer address wrong");
  a_dps_keeps_ptr: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    id_req_i && id_we_i && sfr_hit && sa == 8'h92 && !primary_data_pointer_load_i && !primary_data_pointer_inc_i
    |=> $stable(st.dp0) && $stable(st.dp1))
    else $error("select write changed a pointer");
  a_unmapped_zero: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    xm_req_i && xm_ready_o && !xm_we_i && xr == MM_XR_NONE
    |=> ram_sel_o == 4'h1 ##1 xm_rvalid_o && xm_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_adc_stops: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    mux_slots_i == 4'h0 |=> !st.adc_wr)
    else $error("converter wrote with zero slots");
  a_ce_range: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ce_off_i >= 12'hC00 |=> ce_range_err_o)
    else $error("engine code overrun missed");
  a_bank_map: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    id_req_i && id_rn_i |-> ib.addr[4:3] == st.program_status_word[4:3] && ib.addr[7:5] == 3'h0)
    else $error("bank mapping wrong");
endmodule

/* File: sim/mmap_engine_model.sv */
// Purpose: far-side model of the engine and converter memory
// Assumes: strobes from the block are single cycle and registered
// Notes: idle read data toggles so stale values never match
`timescale 1ns/1ns
module mmap_engine_model import mmap_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic [15:0] ram_addr_i,
  input wire logic [7:0] ram_wdata_i,
  input wire logic ram_we_i,
  input wire logic [3:0] ram_sel_i,
  output logic [7:0] ram_rdata_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  logic rd_sel;
  initial begin
    last = 8'h00;
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end
  assign rd_sel = (ram_sel_i != 4'(MM_XR_NONE)) && !ram_we_i;
  always @(posedge clk_sys_i) begin
    if (ram_we_i && ram_sel_i != 4'(MM_XR_NONE)) mem[ram_addr_i] <= ram_wdata_i;
    last <= ram_rdata_o;
  end
  assign ram_rdata_o = rd_sel ? mem[ram_addr_i] : ~last;
endmodule

/* File: sim/testbench.sv */
// Purpose: self-checking bench for the memory map block
// Assumes: inputs change on the rising edge by non-blocking assignment
// Notes: decode rows in a table, the rest hand-written
`timescale 1ns/1ns
`include "mmap_defines.svh"
module testbench import mmap_pkg::*; ();
  logic clk_sys_i, arst_n_i, fetch_next_i, jump_i, irq_take_i, movc_i, movc_use_pc_i;
  logic primary_data_pointer_inc_i, primary_data_pointer_load_i, id_req_i, id_we_i, id_ind_i, id_rn_i, id_bit_i;
  logic xm_req_i, xm_we_i, xm_primary_data_pointer_i, xm_ri_i, adc_req_i;
  logic [15:0] jump_addr_i, primary_data_pointer_wdata_i, prog_addr_o, ram_addr_o, ce_prog_addr_o;
  logic [4:0] irq_num_i;
  logic [7:0] acc_i, id_addr_i, id_wdata_i, xm_wdata_i, adc_wdata_i, ram_rdata_i;
  logic [7:0] id_rdata_o, xm_rdata_o, ram_wdata_o, rd;
  logic [3:0] mux_slots_i, ram_sel_o;
  logic [5:0] adc_addr_i, ce_base_kb_i;
  logic [11:0] ce_off_i;
  logic id_rvalid_o, xm_ready_o, xm_rvalid_o, ram_we_o, ce_clash_o, ce_range_err_o;
  int fails, num_checks;
  typedef struct packed {logic [15:0] a; mmap_region_t s;} mmap_row_t;
  mmap_row_t rows [10] = '{'{16'h0000, MM_XR_SHARED}, '{16'h13FF, MM_XR_SHARED},
    '{16'h1400, MM_XR_NONE}, '{16'h1FFF, MM_XR_NONE}, '{16'h2000, MM_XR_CFG},
    '{16'h27FF, MM_XR_CFG}, '{16'h2800, MM_XR_BAT}, '{16'h287F, MM_XR_BAT},
    '{16'h2880, MM_XR_NONE}, '{16'hFFFF, MM_XR_NONE}};
  logic [7:0] pb [4] = '{8'h34, 8'h12, 8'h79, 8'h56};

  mmap_top u_dut (.clk_sys_i, .arst_n_i, .fetch_next_i, .jump_i, .jump_addr_i, .irq_take_i,
    .irq_num_i, .movc_i, .movc_use_pc_i, .acc_i, .prog_addr_o, .primary_data_pointer_inc_i, .primary_data_pointer_load_i,
    .primary_data_pointer_wdata_i, .id_req_i, .id_we_i, .id_ind_i, .id_rn_i, .id_bit_i, .id_addr_i,
    .id_wdata_i, .id_rdata_o, .id_rvalid_o, .xm_req_i, .xm_we_i, .xm_primary_data_pointer_i, .xm_ri_i,
    .xm_wdata_i, .xm_ready_o, .xm_rdata_o, .xm_rvalid_o, .mux_slots_i, .adc_req_i,
    .adc_addr_i, .adc_wdata_i, .ram_addr_o, .ram_wdata_o, .ram_we_o, .ram_sel_o,
    .ram_rdata_i, .ce_clash_o, .ce_base_kb_i, .ce_off_i, .ce_prog_addr_o, .ce_range_err_o);
  mmap_engine_model u_eng (.clk_sys_i, .ram_addr_i(ram_addr_o), .ram_wdata_i(ram_wdata_o),
    .ram_we_i(ram_we_o), .ram_sel_i(ram_sel_o), .ram_rdata_o(ram_rdata_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic id_op(input logic we, ind, rn, bt, input logic [7:0] a, wd);
    @(posedge clk_sys_i);
    {id_req_i, id_we_i, id_ind_i, id_rn_i, id_bit_i} <= {1'b1, we, ind, rn, bt};
    id_addr_i <= a;
    id_wdata_i <= wd;
    @(posedge clk_sys_i);
    id_req_i <= 1'b0;
    #1;
    rd = id_rdata_o;
    if (!we) chk("id_rvalid", 16'h1, 16'(id_rvalid_o));
  endtask

  task automatic idr(input logic [7:0] a, input logic ind, bt, input logic [7:0] e);
    id_op(1'b0, ind, 1'b0, bt, a, 8'h00);
    chk("id_rdata", 16'(e), 16'(rd));
  endtask

  task automatic xm_op(input logic we, dp, ri, input logic [7:0] wd, input logic [15:0] ea,
      input mmap_region_t es, input logic [7:0] er);
    @(posedge clk_sys_i);
    {xm_req_i, xm_we_i, xm_primary_data_pointer_i, xm_ri_i} <= {1'b1, we, dp, ri};
    xm_wdata_i <= wd;
    @(posedge clk_sys_i);
    xm_req_i <= 1'b0;
    #1;
    if (es != MM_XR_NONE) chk("ram_addr", ea, ram_addr_o);
    chk("ram_sel", 16'(es), 16'(ram_sel_o));
    chk("ram_we", 16'(we && es != MM_XR_NONE), 16'(ram_we_o));
    chk("ce_clash", 16'(we && ea <= `MM_CE_HI), 16'(ce_clash_o));
    @(posedge clk_sys_i);
    #1;
    if (!we) chk("xm_rdata", 16'(er), 16'(xm_rdata_o));
    if (!we) chk("xm_rvalid", 16'h1, 16'(xm_rvalid_o));
  endtask

  task automatic ptr(input logic ld, inc, input logic [15:0] v);
    @(posedge clk_sys_i);
    {primary_data_pointer_load_i, primary_data_pointer_inc_i, primary_data_pointer_wdata_i} <= {ld, inc, v};
    @(posedge clk_sys_i);
    {primary_data_pointer_load_i, primary_data_pointer_inc_i} <= 2'b00;
  endtask

  // kind: 0 fetch, 1 jump, 2 interrupt, 3 table via pc, 4 table via pointer
  task automatic pg(input int k, input logic [15:0] v, input logic [7:0] acc,
      input logic [15:0] e);
    @(posedge clk_sys_i);
    {fetch_next_i, jump_i, irq_take_i, movc_i} <= {k == 0, k == 1, k == 2, k >= 3};
    {jump_addr_i, irq_num_i, movc_use_pc_i, acc_i} <= {v, v[4:0], k == 3, acc};
    @(posedge clk_sys_i);
    {fetch_next_i, jump_i, irq_take_i, movc_i} <= 4'h0;
    #1;
    chk("prog_addr", e, prog_addr_o);
  endtask

  task automatic adc(input logic [3:0] sl, input logic [5:0] a, input logic go);
    @(posedge clk_sys_i);
    {mux_slots_i, adc_req_i, adc_addr_i, adc_wdata_i} <= {sl, 1'b1, a, 8'h5A};
    #1;
    chk("xm_ready", 16'(!go), 16'(xm_ready_o));
    @(posedge clk_sys_i);
    adc_req_i <= 1'b0;
    #1;
    chk("ram_we", 16'(go), 16'(ram_we_o));
    if (go) chk("ram_addr", 16'(a), ram_addr_o);
    if (go) chk("ram_wdata", 16'h005A, 16'(ram_wdata_o));
  endtask

  task automatic ce(input logic [5:0] b, input logic [11:0] o, input logic [15:0] e,
      input logic er);
    @(posedge clk_sys_i);
    {ce_base_kb_i, ce_off_i} <= {b, o};
    @(posedge clk_sys_i);
    #1;
    chk("ce_prog_addr", e, ce_prog_addr_o);
    chk("ce_range_err", 16'(er), 16'(ce_range_err_o));
  endtask

  initial begin
    #(50 * 3000);
    fails++;
    summarize();
  end

  initial begin
    {arst_n_i, fetch_next_i, jump_i, irq_take_i, movc_i, movc_use_pc_i, primary_data_pointer_inc_i} = '0;
    {primary_data_pointer_load_i, id_req_i, id_we_i, id_ind_i, id_rn_i, id_bit_i, xm_req_i, xm_we_i} = '0;
    {xm_primary_data_pointer_i, xm_ri_i, adc_req_i, jump_addr_i, primary_data_pointer_wdata_i, irq_num_i, acc_i} = '0;
    {id_addr_i, id_wdata_i, xm_wdata_i, adc_wdata_i, mux_slots_i, adc_addr_i} = '0;
    {ce_base_kb_i, ce_off_i} = '0;
    {fails, num_checks} = '0;
    @(posedge clk_sys_i);
    #1;
    chk("prog_addr", `MM_PC_RESET, prog_addr_o);
    chk("ram_sel", 16'(MM_XR_NONE), 16'(ram_sel_o));
    @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    foreach (pb[i]) idr(8'(`MM_SFR_DPL0 + i), 1'b0, 1'b0, `MM_RST_BYTE);
    foreach (rows[i]) begin
      ptr(1'b1, 1'b0, rows[i].a);
      xm_op(1'b1, 1'b1, 1'b0, 8'(8'h40 + i), rows[i].a, rows[i].s, 8'h00);
      xm_op(1'b0, 1'b1, 1'b0, 8'h00, rows[i].a, rows[i].s,
        rows[i].s == MM_XR_NONE ? 8'h00 : 8'(8'h40 + i));
    end
    pg(0, 16'h0000, 8'h00, 16'h0001);
    for (int n = 0; n < 32; n += 7) begin
      pg(2, 16'(n), 8'h00, 16'(`MM_VEC_BASE + (n << `MM_VEC_SHIFT)));
    end
    pg(1, 16'hFFFF, 8'h00, 16'hFFFF);
    pg(0, 16'h0000, 8'h00, 16'h0000);
    pg(1, 16'h1000, 8'h00, 16'h1000);
    pg(3, 16'h0000, 8'h10, 16'h1010);
    ptr(1'b1, 1'b0, 16'h1234);
    id_op(1'b1, 1'b0, 1'b0, 1'b0, `MM_SFR_DPS, 8'h01);
    ptr(1'b1, 1'b0, 16'h5678);
    ptr(1'b0, 1'b1, 16'h0000);
    foreach (pb[i]) idr(8'(`MM_SFR_DPL0 + i), 1'b0, 1'b0, pb[i]);
    xm_op(1'b0, 1'b1, 1'b0, 8'h00, 16'h5679, MM_XR_NONE, 8'h00);
    pg(4, 16'h0000, 8'h07, 16'h5680);
    id_op(1'b1, 1'b0, 1'b0, 1'b0, `MM_SFR_DPS, 8'h00);
    ptr(1'b0, 1'b1, 16'h0000);
    idr(`MM_SFR_DPL0, 1'b0, 1'b0, 8'h35);
    for (int b = 0; b < 4; b++) begin
      id_op(1'b1, 1'b0, 1'b0, 1'b0, `MM_SFR_PSW, 8'(b << `MM_PSW_RS_LO));
      id_op(1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 8'(8'h60 + b));
      idr(8'(8 * b), 1'b0, 1'b0, 8'(8'h60 + b));
    end
    id_op(1'b1, 1'b0, 1'b1, 1'b0, 8'h01, 8'h7F);
    id_op(1'b1, 1'b0, 1'b0, 1'b0, `MM_SFR_PAGE, 8'h28);
    xm_op(1'b1, 1'b0, 1'b1, 8'hC3, 16'h287F, MM_XR_BAT, 8'h00);
    xm_op(1'b0, 1'b0, 1'b1, 8'h00, 16'h287F, MM_XR_BAT, 8'hC3);
    idr(8'h19, 1'b1, 1'b0, 8'h7F);
    id_op(1'b1, 1'b1, 1'b0, 1'b0, `MM_SFR_DPS, 8'hA5);
    idr(`MM_SFR_DPS, 1'b1, 1'b0, 8'hA5);
    idr(`MM_SFR_DPS, 1'b0, 1'b0, 8'h00);
    id_op(1'b1, 1'b0, 1'b0, 1'b0, 8'h93, 8'hFF);
    idr(8'h93, 1'b0, 1'b0, 8'h00);
    idr(8'h93, 1'b1, 1'b0, 8'h00);
    id_op(1'b1, 1'b0, 1'b0, 1'b1, 8'h0A, 8'h01);
    idr(8'h21, 1'b0, 1'b0, 8'h04);
    idr(8'h0A, 1'b0, 1'b1, 8'h01);
    id_op(1'b1, 1'b0, 1'b0, 1'b1, 8'hD5, 8'h01);
    idr(`MM_SFR_PSW, 1'b0, 1'b0, 8'h38);
    // slot count set in the same cycle as each converter request
    adc(4'h3, 6'h3F, 1'b1);
    adc(4'h0, 6'h10, 1'b0);
    adc(4'hF, 6'h00, 1'b1);
    ce(6'h03, 12'hBFF, 16'h17FF, 1'b0);
    ce(6'h01, `MM_CE_MAX_OFF, 16'h1000, 1'b1);
    summarize();
  end
endmodule
